// ==== inc/lmx_pkg.sv ====
// Constants, configuration layouts and source bundle of the LED latch matrix.
package lmx_pkg;
    // Matrix dimensions.
    localparam int LED_N    = 14;
    localparam int OBJ_N    = 8;
    localparam int SRC_W    = 8;
    localparam int SRC_N    = 256;
    localparam int PULSE_N  = 16;          // Source indices below this are short event pulses.
    localparam int LOCAL_IX = 196;         // Index of the local-control-enabled source.

    // Timing; the tick count is derived from the 100 ns clock period, the other counts are in milliseconds.
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_NS       = 1000000;                    // One millisecond.
    localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;
    localparam int LED_DELAY_MS  = 10;
    localparam int BLINK_HALF_MS = 250;

    // Register byte offsets.
    localparam logic [7:0] LED_CFG_BASE = 8'h00;
    localparam logic [7:0] OBJ_CFG_BASE = 8'h40;
    localparam logic [7:0] REL_CTRL     = 8'h60;
    localparam logic [7:0] STATUS       = 8'h64;
    localparam logic [7:0] LED_OUT      = 8'h68;

    // Release control fields and reset value.
    localparam int REL_SW_BIT  = 0;
    localparam int REL_FB1_BIT = 1;
    localparam int REL_FB2_BIT = 2;
    localparam int REL_LEN_LSB = 16;
    localparam int REL_LEN_W   = 16;
    localparam logic [15:0] REL_LEN_RST = 16'h03e8;           // 1000 ms.
    localparam int STAT_REL_BIT = 16;
    localparam int OUT_RED_LSB  = 16;

    // Per-indicator configuration, bits 12 down to 0 of its register.
    typedef struct packed {
        logic             store;
        logic             blink;
        logic             latch;
        logic             red;
        logic             en;
        logic [SRC_W-1:0] src;
    } lmx_led_cfg_t;

    // Per-object inhibit configuration, bits 8 down to 0 of its register.
    typedef struct packed {
        logic             en;
        logic [SRC_W-1:0] src;
    } lmx_obj_cfg_t;

    // Status sources; the last member lands on matrix index 0.
    typedef struct packed {
        logic [15:0] net_error_flag;        // network_error_flag 1..16
        logic [63:0] net_status_input;      // network_status_input 1..64
        logic [3:0]  self_diag;
        logic [4:0]  comm_port_activity;
        logic        manual_ctrl;
        logic [19:0] logic_out;
        logic [15:0] obj_state;             // Final trip 8, failure 8.
        logic [1:0]  func_button;           // function_button_two, function_button_one
        logic [19:0] virt_in;
        logic [15:0] dig_in;
        logic [15:0] prot_stage;
        logic [15:0] obj_cmd_pulse;         // Open 8, close 8 (event type).
    } lmx_src_t;

    // Release sequencer states.
    typedef enum logic [1:0] {
        REL_IDLE  = 2'b01,
        REL_PULSE = 2'b10
    } lmx_rel_state_t;
endpackage

// ==== core/lmx_core.sv ====
// LED latch matrix with object inhibit matrix and common latch release, AHB-Lite slave.
//
// Our own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps

// How it works
// - Normal mode lamp follows its source, updated every 10 ms.
// - Latched mode lamp sets with source and holds until released.
// - Blink option toggles the lamp while it is active.
// - Stored latches survive a restart instead of clearing.
// - Store only acts when latching is also enabled.
// - Fourteen indicators, each selectable green or red.
// - Modes are normal, latched and blinking latched; the blink bit also blinks a lamp in normal mode.
// - Indicators are driven only through the matrix, never directly.
// - Local-control-enabled source follows the local/remote selection.
// - All twenty logic outputs are selectable sources.
// - Five comm port activity signals are selectable sources.
// - Sixty-four network inputs and sixteen network error flags are sources.
// - Inhibit matrix blocks object control while chosen source is on.
// - Event pulse sources never inhibit objects.
// - Configured function button triggers the common release.
// - Release is a pulse of configurable length in milliseconds.
// - Release starts only while some latch is active.
// - Release clears latched indicators and latched digital outputs together.
module lmx_core #(
    parameter int TICK_CYCLES = lmx_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic                   clock_i,
    input  wire logic                   reset_n_i,
    // AHB-Lite slave.
    input  wire logic                   hsel_i,
    input  wire logic [31:0]            haddr_i,
    input  wire logic [1:0]             htrans_i,
    input  wire logic                   hwrite_i,
    input  wire logic [2:0]             hsize_i,
    input  wire logic [31:0]            hwdata_i,
    input  wire logic                   hready_i,
    output logic      [31:0]            hrdata_o,
    output logic                        hreadyout_o,
    output logic                        hresp_o,
    // Relay status.
    input  wire lmx_pkg::lmx_src_t      src_i,
    input  wire logic                   local_mode_i,
    input  wire logic                   release_i,
    input  wire logic                   restart_i,
    // Indicators, object inhibits and common release.
    output logic [lmx_pkg::LED_N-1:0]   led_green_o,
    output logic [lmx_pkg::LED_N-1:0]   led_red_o,
    output logic [lmx_pkg::OBJ_N-1:0]   obj_inhibit_o,
    output logic                        release_pulse_o
);
    lmx_pkg::lmx_led_cfg_t led_cfg [lmx_pkg::LED_N];
    lmx_pkg::lmx_obj_cfg_t obj_cfg [lmx_pkg::OBJ_N];
    logic [lmx_pkg::REL_LEN_W-1:0] rel_len;
    logic                   fb1_rel_en;
    logic                   fb2_rel_en;
    logic                   wr_pend;
    logic [7:0]             wr_addr;
    logic [23:0]            tick_cnt;
    logic [7:0]             refresh_cnt;
    logic [7:0]             blink_cnt;
    logic                   blink_phase;
    logic [lmx_pkg::LED_N-1:0] latch;
    logic [1:0]             fb_prev;
    logic                   rel_in_prev;
    lmx_pkg::lmx_rel_state_t rel_state;
    lmx_pkg::lmx_rel_state_t next_rel_state;
    logic [lmx_pkg::REL_LEN_W-1:0] rel_cnt;
    logic [lmx_pkg::REL_LEN_W-1:0] next_rel_cnt;

    // Source vector: local control, then the bundle, padded to the index range.
    wire [lmx_pkg::SRC_N-1:0] src_vec = {59'h0, local_mode_i, src_i};

    // Bus decode; only the low 256 bytes are mapped; the configuration slots ignore address bits 1:0.
    // Every taken read loads the data register, so an unmapped read returns zero, not stale data.
    wire       addr_ok  = hsel_i && htrans_i[1] && hready_i && (haddr_i[31:8] == 24'h0);
    wire       rd_take  = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    wire       wr_take  = addr_ok && hwrite_i;
    wire [7:0] ra       = haddr_i[7:0];
    wire       led_hit  = (ra[7:6] == 2'b00) && (ra[5:2] < 4'(lmx_pkg::LED_N));
    wire       obj_hit  = (ra[7:5] == 3'b010);
    wire [31:0] rd_word =
        !addr_ok ? 32'h0 :
        led_hit ? {19'h0, led_cfg[ra[5:2]]} :
        obj_hit ? {23'h0, obj_cfg[ra[4:2]]} :
        (ra == lmx_pkg::REL_CTRL) ? {rel_len, 13'h0, fb2_rel_en, fb1_rel_en, 1'b0} :
        (ra == lmx_pkg::STATUS)   ? {15'h0, rel_state == lmx_pkg::REL_PULSE, 2'h0, latch} :
        (ra == lmx_pkg::LED_OUT)  ? {2'h0, led_red_o, 2'h0, led_green_o} : 32'h0;

    // Write-phase decode.
    wire wr_led = wr_pend && (wr_addr[7:6] == 2'b00) && (wr_addr[5:2] < 4'(lmx_pkg::LED_N));
    wire wr_obj = wr_pend && (wr_addr[7:5] == 3'b010);
    wire wr_rel = wr_pend && (wr_addr == lmx_pkg::REL_CTRL);

    // Bus slave: zero wait states, read data registered from the address phase.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_o    <= 32'h0;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            wr_pend     <= 1'b0;
            wr_addr     <= 8'h0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
            wr_pend     <= wr_take;
            wr_addr     <= ra;
            if (rd_take) begin
                hrdata_o <= rd_word;
            end
        end
    end

    // Release control register; configuration survives a restart like stored settings.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rel_len    <= lmx_pkg::REL_LEN_RST;
            fb1_rel_en <= 1'b0;
            fb2_rel_en <= 1'b0;
        end else if (wr_rel) begin
            rel_len    <= hwdata_i[lmx_pkg::REL_LEN_LSB +: lmx_pkg::REL_LEN_W];
            fb1_rel_en <= hwdata_i[lmx_pkg::REL_FB1_BIT];
            fb2_rel_en <= hwdata_i[lmx_pkg::REL_FB2_BIT];
        end
    end

    // Millisecond tick; the long count is a parameter so simulation can shorten it.
    wire tick = (tick_cnt == 24'(TICK_CYCLES - 1));
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tick_cnt <= 24'h0;
        end else begin
            tick_cnt <= tick ? 24'h0 : tick_cnt + 24'h1;
        end
    end

    // Refresh every 10 ms and a fixed blink half period.
    wire refresh   = tick && (refresh_cnt == 8'(lmx_pkg::LED_DELAY_MS - 1));
    wire blink_end = tick && (blink_cnt == 8'(lmx_pkg::BLINK_HALF_MS - 1));
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            refresh_cnt <= 8'h0;
            blink_cnt   <= 8'h0;
            blink_phase <= 1'b0;
        end else if (tick) begin
            refresh_cnt <= refresh ? 8'h0 : refresh_cnt + 8'h1;
            blink_cnt   <= blink_end ? 8'h0 : blink_cnt + 8'h1;
            blink_phase <= blink_phase ^ blink_end;
        end
    end

    // Release requests: software bit, function buttons, external release input.
    wire [1:0] fb_rise  = src_i.func_button & ~fb_prev;
    wire sw_rel         = wr_rel && hwdata_i[lmx_pkg::REL_SW_BIT];
    wire fb_rel         = (fb_rise[0] && fb1_rel_en) || (fb_rise[1] && fb2_rel_en);
    wire rel_req        = sw_rel || fb_rel || (release_i && !rel_in_prev);
    wire rel_active     = (rel_state == lmx_pkg::REL_PULSE);

    // Release sequencer; a pulse with nothing latched would have no effect, so none starts.
    always_comb begin
        next_rel_state = rel_state;
        next_rel_cnt   = rel_cnt;
        case (rel_state)
            lmx_pkg::REL_IDLE: begin
                if (rel_req && (|latch)) begin
                    next_rel_state = lmx_pkg::REL_PULSE;
                    next_rel_cnt   = rel_len;
                end
            end
            lmx_pkg::REL_PULSE: begin
                if (tick) begin
                    if (rel_cnt <= 16'h0001) begin
                        next_rel_state = lmx_pkg::REL_IDLE;
                        next_rel_cnt   = 16'h0;
                    end else begin
                        next_rel_cnt = rel_cnt - 16'h0001;
                    end
                end
            end
            default: begin
                next_rel_state = lmx_pkg::REL_IDLE;
                next_rel_cnt   = 16'h0;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rel_state       <= lmx_pkg::REL_IDLE;
            rel_cnt         <= 16'h0;
            release_pulse_o <= 1'b0;
            fb_prev         <= 2'b00;
            rel_in_prev     <= 1'b0;
        end else begin
            rel_state       <= next_rel_state;
            rel_cnt         <= next_rel_cnt;
            release_pulse_o <= (next_rel_state == lmx_pkg::REL_PULSE);
            fb_prev         <= src_i.func_button;
            rel_in_prev     <= release_i;
        end
    end

    // One slice per indicator: configuration, latch and lamp drive.
    genvar gi;
    generate
        for (gi = 0; gi < lmx_pkg::LED_N; gi++) begin : g_led
            wire this_wr = wr_led && (wr_addr[5:2] == 4'(gi));
            wire src_on  = led_cfg[gi].en && src_vec[led_cfg[gi].src];
            wire keep    = led_cfg[gi].store && led_cfg[gi].latch;
            wire active  = led_cfg[gi].latch ? latch[gi] : src_on;
            wire lit     = active && (!led_cfg[gi].blink || blink_phase);

            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    led_cfg[gi] <= '0;
                end else if (this_wr) begin
                    led_cfg[gi] <= hwdata_i[12:0];
                end
            end

            // A source that is on during a release sets the latch again.
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    latch[gi] <= 1'b0;
                end else if (restart_i) begin
                    latch[gi] <= latch[gi] && keep;
                end else begin
                    latch[gi] <= ((latch[gi] && !rel_active) || src_on)
                                 && led_cfg[gi].latch;
                end
            end

            // Lamps refresh on the 10 ms grid, which gives the lamp latency.
            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    led_green_o[gi] <= 1'b0;
                    led_red_o[gi]   <= 1'b0;
                end else if (refresh) begin
                    led_green_o[gi] <= lit && !led_cfg[gi].red;
                    led_red_o[gi]   <= lit && led_cfg[gi].red;
                end
            end
        end
    endgenerate

    // One slice per object of the inhibit matrix.
    genvar gj;
    generate
        for (gj = 0; gj < lmx_pkg::OBJ_N; gj++) begin : g_obj
            wire this_wr = wr_obj && (wr_addr[4:2] == 3'(gj));
            wire level   = (obj_cfg[gj].src >= 8'(lmx_pkg::PULSE_N));

            always_ff @(posedge clock_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    obj_cfg[gj]       <= '0;
                    obj_inhibit_o[gj] <= 1'b0;
                end else begin
                    if (this_wr) begin
                        obj_cfg[gj] <= hwdata_i[8:0];
                    end
                    obj_inhibit_o[gj] <= obj_cfg[gj].en && level
                                         && src_vec[obj_cfg[gj].src];
                end
            end
        end
    endgenerate
endmodule

// ==== tb/lmx_core_sva.sv ====
// Port assertions of the LED latch matrix.
`timescale 1ns/1ps
module lmx_core_sva #(
    parameter int TICK_CYCLES = 10
) (
    // Clock, reset and bus.
    input wire logic                      clock_i,
    input wire logic                      reset_n_i,
    input wire logic                      hsel_i,
    input wire logic [31:0]               haddr_i,
    input wire logic [1:0]                htrans_i,
    input wire logic                      hwrite_i,
    input wire logic                      hready_i,
    input wire logic [31:0]               hrdata_o,
    input wire logic                      hreadyout_o,
    input wire logic                      hresp_o,
    // Sources and lamps.
    input wire lmx_pkg::lmx_src_t         src_i,
    input wire logic                      release_i,
    input wire logic [lmx_pkg::LED_N-1:0] led_green_o,
    input wire logic [lmx_pkg::LED_N-1:0] led_red_o,
    input wire logic                      release_pulse_o
);
    logic        rel_q;
    logic [1:0]  btn_q;
    logic [7:0]  req_hist;
    logic [15:0] pulse_len;
    wire         rd_take = hsel_i & htrans_i[1] & ~hwrite_i & hready_i;
    wire         req_now = (release_i & ~rel_q) | (|(src_i.func_button & ~btn_q))
                         | (hsel_i & htrans_i[1] & hwrite_i & hready_i);

    // Recent request history; kept wide so bus latency cannot hide a cause.
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rel_q     <= 1'b0;
            btn_q     <= 2'b00;
            req_hist  <= 8'h00;
            pulse_len <= 16'h0000;
        end else begin
            rel_q     <= release_i;
            btn_q     <= src_i.func_button;
            req_hist  <= {req_hist[6:0], req_now};
            pulse_len <= release_pulse_o ? pulse_len + 16'h0001 : 16'h0000;
        end
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    property p_okay;
        hreadyout_o && !hresp_o;
    endproperty
    a_okay: assert property (p_okay) else $error("bus not ready or not OKAY");
    property p_unmapped;
        rd_take && haddr_i[31:8] != 24'h000000 |=> hrdata_o == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_led_out;
        rd_take && haddr_i == 32'(lmx_pkg::LED_OUT)
        |=> hrdata_o == {2'b00, $past(led_red_o), 2'b00, $past(led_green_o)};
    endproperty
    a_led_out: assert property (p_led_out) else $error("lamp readback wrong");
    property p_one_colour;
        (led_green_o & led_red_o) == '0;
    endproperty
    a_one_colour: assert property (p_one_colour) else $error("lamp in two colours");
    property p_refresh;
        $changed({led_green_o, led_red_o}) |=> $stable({led_green_o, led_red_o})[*8];
    endproperty
    a_refresh: assert property (p_refresh) else $error("lamp changed off refresh");
    property p_pulse_min;
        $fell(release_pulse_o) |-> pulse_len >= 16'(TICK_CYCLES - 1);
    endproperty
    a_pulse_min: assert property (p_pulse_min) else $error("release pulse too short");
    property p_rel_cause;
        $rose(release_pulse_o) |-> |req_hist;
    endproperty
    a_rel_cause: assert property (p_rel_cause) else $error("release without request");
    property p_reset_clear;
        !$past(reset_n_i) |-> led_green_o == '0 && led_red_o == '0 && !release_pulse_o;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("outputs not clear at reset");

    c_pulse: cover property ($rose(release_pulse_o));
    c_lamp: cover property ($rose(|led_green_o));
    c_unmapped: cover property (rd_take && haddr_i[31:8] != 24'h000000);
endmodule

// ==== tb/tb_lmx_core.sv ====
// Self-checking testbench of the LED latch matrix.
`timescale 1ns/1ps
module tb_lmx_core;
    localparam int TICKC = 10;
    localparam int LAMP  = 102;   // One lamp refresh plus margin.
    logic              clock_i    = 1'b0;
    logic              reset_n_i  = 1'b0;
    logic              hsel       = 1'b0;
    logic [31:0]       haddr      = '0;
    logic [1:0]        htrans     = '0;
    logic              hwrite     = 1'b0;
    logic [31:0]       hwdata     = '0;
    lmx_pkg::lmx_src_t src        = '0;
    logic              local_mode = 1'b0;
    logic              rel_in     = 1'b0;
    logic              restart    = 1'b0;
    logic [31:0]       hrdata;
    logic              hready;
    logic [13:0]       led_g;
    logic [13:0]       led_r;
    logic [7:0]        inhib;
    logic              rel_pulse;
    logic [31:0]       rd;
    int                error_cnt  = 0;
    int                n_checks   = 0;
    int                cycles     = 0;

    lmx_core #(.TICK_CYCLES(TICKC)) u_lmx_core (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(),
        .src_i(src), .local_mode_i(local_mode), .release_i(rel_in), .restart_i(restart),
        .led_green_o(led_g), .led_red_o(led_r), .obj_inhibit_o(inhib),
        .release_pulse_o(rel_pulse));

    // Clock and a cycle ceiling that cuts a hung run short.
    always #50 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 40000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // One single transfer; waiting an edge first avoids driving twice in one step.
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock_i);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge clock_i); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    // Source index 196 is the local selection, the rest are bits of the bundle.
    task automatic put(input int ix, input logic v);
        if (ix == 196) local_mode <= v;
        else src[ix] <= v;
    endtask
    // Waits ending on a falling edge so registered outputs have settled.
    task automatic tk(input int n);
        repeat (n) @(posedge clock_i);
        @(negedge clock_i);
    endtask
    function automatic logic [31:0] cfg(input int s, input logic [4:0] f);
        return {19'h0, f, 8'(s)};
    endfunction

    task automatic t_regs();
        bus(0, lmx_pkg::REL_CTRL, 0);
        chk("rel_ctrl reset", 32'h03e80000, rd);
        bus(1, 52, cfg(5, 5'h1f));
        bus(0, 52, 0);
        chk("led cfg back", 32'h00001f05, rd);
        bus(1, 32'h100, 32'hffffffff);
        bus(0, 32'h100, 0);
        chk("unmapped", 0, rd);
        bus(0, 32'h6c, 0);
        chk("gap", 0, rd);
    endtask
    task automatic t_normal();
        int s[7] = '{16, 86, 107, 116, 180, 195, 196};
        for (int k = 0; k < 7; k++) bus(1, 4 * k, cfg(s[k], {3'b000, k[0], 1'b1}));
        bus(1, 28, cfg(16, 5'h00));
        foreach (s[k]) put(s[k], 1'b1);
        tk(LAMP);
        chk("green on", 32'h55, led_g);
        chk("red on", 32'h2a, led_r);
        bus(0, lmx_pkg::LED_OUT, 0);
        chk("led_out", 32'h002a0055, rd);
        foreach (s[k]) put(s[k], 1'b0);
        tk(LAMP);
        chk("all dark", 0, {led_r, led_g});
    endtask
    task automatic t_release();
        int len;
        bus(1, 32, cfg(32, 5'h05));
        bus(1, lmx_pkg::REL_CTRL, 32'h00020003);
        len = 0;
        repeat (30) begin
            @(negedge clock_i);
            len += rel_pulse;
        end
        chk("idle release", 0, len);
        for (int m = 0; m < 4; m++) begin
            @(posedge clock_i);
            put(32, 1'b1);
            @(posedge clock_i);
            put(32, 1'b0);
            tk(LAMP);
            chk("latched held", 1, led_g[8]);
            if (m == 0) begin
                bus(0, lmx_pkg::STATUS, 0);
                chk("status latch", 32'h100, rd);
                bus(1, lmx_pkg::REL_CTRL, 32'h00020007);
            end else begin
                @(posedge clock_i);
                if (m == 1) put(68, 1'b1);
                else if (m == 2) rel_in <= 1'b1;
                else put(69, 1'b1);
            end
            len = 0;
            repeat (60) begin
                @(negedge clock_i);
                len += rel_pulse;
            end
            @(posedge clock_i);
            put(68, 1'b0);
            put(69, 1'b0);
            rel_in <= 1'b0;
            chk("pulse length", 1, len >= 10 && len <= 30);
            tk(LAMP);
            chk("released", 0, led_g[8]);
        end
    endtask
    task automatic t_blink();
        int n;
        bus(1, 36, cfg(48, 5'h0d));
        put(48, 1'b1);
        for (int p = 0; p < 4; p++) begin
            n = 0;
            while (led_g[9] === p[0] && n < 3000) begin
                @(negedge clock_i);
                n++;
            end
        end
        chk("blink half", 1, n >= 2300 && n <= 2700);
        @(posedge clock_i);
        put(48, 1'b0);
        bus(1, lmx_pkg::REL_CTRL, 32'h00020001);
        tk(60 + LAMP);
        chk("blink released", 0, led_g[9]);
    endtask
    task automatic t_store();
        bus(1, 40, cfg(33, 5'h15));
        bus(1, 44, cfg(34, 5'h05));
        put(33, 1'b1);
        put(34, 1'b1);
        @(posedge clock_i);
        put(33, 1'b0);
        put(34, 1'b0);
        restart <= 1'b1;
        @(posedge clock_i);
        restart <= 1'b0;
        tk(LAMP);
        chk("stored latch", 32'h1, led_g[11:10]);
    endtask
    task automatic t_inhibit();
        bus(1, lmx_pkg::OBJ_CFG_BASE, 32'h110);
        bus(1, 32'h44, 32'h100);
        bus(1, 32'h48, 32'h1c4);
        put(16, 1'b1);
        put(0, 1'b1);
        put(196, 1'b1);
        tk(3);
        chk("inhibit", 32'h05, inhib);
        @(posedge clock_i);
        put(16, 1'b0);
        put(196, 1'b0);
        tk(3);
        chk("inhibit off", 0, inhib);
    endtask

    initial begin
        repeat (16) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_normal();
        t_release();
        t_blink();
        t_store();
        t_inhibit();
        complete_run();
    end
endmodule

bind lmx_core lmx_core_sva #(.TICK_CYCLES(TICK_CYCLES)) u_lmx_core_sva (
    .clock_i, .reset_n_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o,
    .hreadyout_o, .hresp_o, .src_i, .release_i, .led_green_o, .led_red_o, .release_pulse_o);
